// ==== design/mfr_status_and_telemetry_readback.sv ====
// manufacturer status byte and adc telemetry readback behind the command read port
`timescale 1ns/1ps
`default_nettype none
`include "mfr_defs.svh"

module mfr_status_and_telemetry_readback (
	input wire logic mclk_i,
	input wire logic rstn_i,
	// command read port from the protocol engine, same clock
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_code_i,
	input wire mfr_pkg::page_t page_i,
	output logic rd_valid_o,
	output logic [15:0] rd_data_o,
	output logic rd_two_bytes_o,
	output logic rd_l11_o,
	output logic rd_unsupported_o,
	// per-channel and global events and levels from the sequencer and servo logic
	input wire logic [7:0] discharge_fault_i,
	input wire logic [7:0] on_attempt_i,
	input wire logic [7:0] line0_shutdown_i,
	input wire logic [7:0] line1_shutdown_i,
	input wire logic [7:0] servo_reached_i,
	input wire logic [7:0] dac_connected_i,
	input wire logic [7:0] servo_sat_i,
	input wire logic [7:0] user_on_cmd_i,
	input wire logic [7:0] history_clear_i,
	input wire logic clear_faults_i,
	input wire logic vinen_faulted_off_i,
	input wire logic watchdog_fault_i,
	input wire logic [7:0] adc_hires_cfg_i,
	// shared fault lines, asynchronous pins, active low
	input wire logic shared_fault_line0_n_i,
	input wire logic shared_fault_line1_n_i,
	// adc sample delivery, already formatted as linear words
	input wire logic adc_valid_i,
	input wire mfr_pkg::adc_src_t adc_src_i,
	input wire mfr_pkg::page_t adc_chan_i,
	input wire mfr_pkg::word_t adc_word_i,
	// outputs to the pin and to the rest of the part
	output logic alert_out_n_o,
	output logic [7:0] off_event_o,
	output logic [7:0] adc_hires_sel_o
);
	import mfr_pkg::*;

	// two-stage synchronisers for the shared fault pins
	logic [1:0] line0_sync_ff;
	logic [1:0] line1_sync_ff;
	logic line0_low;
	logic line1_low;

	// global status bits
	logic vinen_off_ff;
	logic watchdog_ff;

	// stored readings
	word_t vin_ff;
	word_t temp_ff;
	word_t vout_mem_ff [`NUM_CHAN];
	logic [7:0] vout_l11_ff;

	// per-channel status outputs
	logic [7:0] chan_byte [`NUM_CHAN];
	logic [7:0] chan_alerting;
	logic [7:0] chan_off_event;

	// read path
	logic rd_valid_ff;
	word_t rd_data_ff;
	logic rd_two_bytes_ff;
	logic rd_l11_ff;
	logic rd_unsupported_ff;
	word_t nxt_rd_data;
	logic nxt_rd_l11;
	logic [7:0] paged_byte;

	// side outputs
	logic alert_n_ff;
	logic [7:0] off_event_ff;
	logic [7:0] hires_sel_ff;

	// known command codes; used for the word-length flag and for the refusal flag
	function automatic logic cmd_known(input logic [7:0] code);
		case (code)
			`CMD_MFR_STATUS: cmd_known = 1'b1;
			`CMD_READ_VIN: cmd_known = 1'b1;
			`CMD_READ_VOUT: cmd_known = 1'b1;
			`CMD_READ_TEMP: cmd_known = 1'b1;
			`CMD_PROTO_REV: cmd_known = 1'b1;
			default: cmd_known = 1'b0;
		endcase
	endfunction : cmd_known

	// byte-wide answers; every other known command answers with a word
	function automatic logic cmd_is_byte(input logic [7:0] code);
		case (code)
			`CMD_MFR_STATUS: cmd_is_byte = 1'b1;
			`CMD_PROTO_REV: cmd_is_byte = 1'b1;
			default: cmd_is_byte = 1'b0;
		endcase
	endfunction : cmd_is_byte

	// the pins change at any time, so nothing reads them before the second stage
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			line0_sync_ff <= 2'b11;
			line1_sync_ff <= 2'b11;
		end else begin
			line0_sync_ff <= {line0_sync_ff[0], shared_fault_line0_n_i};
			line1_sync_ff <= {line1_sync_ff[0], shared_fault_line1_n_i};
		end
	end

	assign line0_low = ~line0_sync_ff[1];
	assign line1_low = ~line1_sync_ff[1];

	// one status slice per channel
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_CHAN; gi = gi + 1) begin : g_chan
			chan_status u_chan (
				.mclk_i(mclk_i),
				.rstn_i(rstn_i),
				.discharge_fault_i(discharge_fault_i[gi]),
				.on_attempt_i(on_attempt_i[gi]),
				.line0_low_i(line0_low),
				.line1_low_i(line1_low),
				.line0_shutdown_i(line0_shutdown_i[gi]),
				.line1_shutdown_i(line1_shutdown_i[gi]),
				.servo_reached_i(servo_reached_i[gi]),
				.dac_connected_i(dac_connected_i[gi]),
				.servo_sat_i(servo_sat_i[gi]),
				.sticky_clear_i(clear_faults_i | user_on_cmd_i[gi]),
				.history_clear_i(history_clear_i[gi]),
				.status_o(chan_byte[gi]),
				.alerting_o(chan_alerting[gi]),
				.off_event_o(chan_off_event[gi])
			);
		end
	endgenerate

	// input-enable indication follows its source, no latching
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			vinen_off_ff <= 1'b0;
		end else begin
			vinen_off_ff <= vinen_faulted_off_i;
		end
	end

	// watchdog flag is global, so only the fault-clearing command removes it
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			watchdog_ff <= 1'b0;
		end else if (watchdog_fault_i) begin
			watchdog_ff <= 1'b1;
		end else if (clear_faults_i) begin
			watchdog_ff <= 1'b0;
		end
	end

	// resolution select: even channels are forced to low resolution
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hires_sel_ff <= 8'h00;
		end else begin
			hires_sel_ff <= adc_hires_cfg_i & `ODD_CHAN_MASK;
		end
	end

	// latest input voltage and die temperature samples
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			vin_ff <= `RESET_WORD;
			temp_ff <= `RESET_WORD;
		end else if (adc_valid_i) begin
			if (adc_src_i == ADC_SRC_VIN) begin
				vin_ff <= adc_word_i;
			end
			if (adc_src_i == ADC_SRC_TEMP) begin
				temp_ff <= adc_word_i;
			end
		end
	end

	// latest output sample per channel, tagged with the format it was taken in;
	// the tag travels with the word so a config change cannot mislabel an old sample
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < `NUM_CHAN; i++) begin
				vout_mem_ff[i] <= `RESET_WORD;
			end
			vout_l11_ff <= 8'h00;
		end else if (adc_valid_i && adc_src_i == ADC_SRC_VOUT) begin
			vout_mem_ff[adc_chan_i] <= adc_word_i;
			vout_l11_ff[adc_chan_i] <= hires_sel_ff[adc_chan_i];
		end
	end

	// paged bits from the selected channel, global bits from the part
	always_comb begin
		paged_byte = chan_byte[page_i];
		paged_byte[`BIT_VINEN_OFF] = vinen_off_ff;
		paged_byte[`BIT_WATCHDOG] = watchdog_ff;
	end

	// answer selection; page only matters for paged reads
	always_comb begin
		nxt_rd_data = `RESET_WORD;
		nxt_rd_l11 = 1'b0;
		case (cmd_code_i)
			`CMD_MFR_STATUS: begin
				nxt_rd_data = {8'h00, paged_byte};
			end
			`CMD_READ_VIN: begin
				nxt_rd_data = vin_ff;
				nxt_rd_l11 = 1'b1;
			end
			`CMD_READ_VOUT: begin
				nxt_rd_data = vout_mem_ff[page_i];
				nxt_rd_l11 = vout_l11_ff[page_i];
			end
			`CMD_READ_TEMP: begin
				nxt_rd_data = temp_ff;
				nxt_rd_l11 = 1'b1;
			end
			`CMD_PROTO_REV: begin
				nxt_rd_data = {8'h00, `PROTO_REV_VALUE};
			end
			default: begin
				nxt_rd_data = `RESET_WORD;
				nxt_rd_l11 = 1'b0;
			end
		endcase
	end

	// one-cycle answer pulse; data stays until the next request is taken
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_valid_ff <= 1'b0;
		end else begin
			rd_valid_ff <= cmd_valid_i;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_ff <= `RESET_WORD;
			rd_two_bytes_ff <= 1'b0;
			rd_l11_ff <= 1'b0;
			rd_unsupported_ff <= 1'b0;
		end else if (cmd_valid_i) begin
			rd_data_ff <= nxt_rd_data;
			rd_two_bytes_ff <= cmd_known(cmd_code_i) & ~cmd_is_byte(cmd_code_i);
			rd_l11_ff <= nxt_rd_l11;
			rd_unsupported_ff <= ~cmd_known(cmd_code_i);
		end
	end

	// alert follows any alerting flag of any channel, regardless of page
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			alert_n_ff <= 1'b1;
		end else begin
			alert_n_ff <= ~((|chan_alerting) | watchdog_ff);
		end
	end

	// registered turn-off events; watchdog is deliberately absent
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			off_event_ff <= 8'h00;
		end else begin
			off_event_ff <= chan_off_event;
		end
	end

	assign rd_valid_o = rd_valid_ff;
	assign rd_data_o = rd_data_ff;
	assign rd_two_bytes_o = rd_two_bytes_ff;
	assign rd_l11_o = rd_l11_ff;
	assign rd_unsupported_o = rd_unsupported_ff;
	assign alert_out_n_o = alert_n_ff;
	assign off_event_o = off_event_ff;
	assign adc_hires_sel_o = hires_sel_ff;

endmodule : mfr_status_and_telemetry_readback
`default_nettype wire

// ==== design/mfr_defs.svh ====
// command codes, status bit positions, fixed values and constants for the status/telemetry bank
`ifndef MFR_DEFS_SVH
`define MFR_DEFS_SVH

// command codes decoded by the read port
`define CMD_MFR_STATUS 8'h80
`define CMD_READ_VIN 8'h88
`define CMD_READ_VOUT 8'h8b
`define CMD_READ_TEMP 8'h8d
`define CMD_PROTO_REV 8'h98

// fixed protocol revision byte (revision 1.1)
`define PROTO_REV_VALUE 8'h11

// bit positions inside the manufacturer status byte
`define BIT_DISCHARGE 7
`define BIT_FAULT1 6
`define BIT_FAULT0 5
`define BIT_SERVO_REACHED 4
`define BIT_DAC_CONNECTED 3
`define BIT_DAC_SATURATED 2
`define BIT_VINEN_OFF 1
`define BIT_WATCHDOG 0

// channel count and the mask of odd channels, the only ones that may use high resolution
`define NUM_CHAN 8
`define ODD_CHAN_MASK 8'haa

// reset values of stored readings
`define RESET_WORD 16'h0000
`define RESET_STATUS 8'h00

`endif

// ==== design/mfr_pkg.sv ====
// types shared by the status and telemetry readback block
package mfr_pkg;

	typedef logic [2:0] page_t;
	typedef logic [15:0] word_t;
	typedef logic [7:0] byte_t;

	// which measurement an incoming adc sample belongs to
	typedef enum logic [1:0] {
		ADC_SRC_VIN = 2'b00,
		ADC_SRC_VOUT = 2'b01,
		ADC_SRC_TEMP = 2'b10,
		ADC_SRC_NONE = 2'b11
	} adc_src_t;

endpackage : mfr_pkg

// ==== design/chan_status.sv ====
// per-channel paged status flags: sticky fault bits, live servo/dac bits, alert and turn-off events
`timescale 1ns/1ps
`default_nettype none
`include "mfr_defs.svh"

module chan_status (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic discharge_fault_i,
	input wire logic on_attempt_i,
	input wire logic line0_low_i,
	input wire logic line1_low_i,
	input wire logic line0_shutdown_i,
	input wire logic line1_shutdown_i,
	input wire logic servo_reached_i,
	input wire logic dac_connected_i,
	input wire logic servo_sat_i,
	input wire logic sticky_clear_i,
	input wire logic history_clear_i,
	output logic [7:0] status_o,
	output logic alerting_o,
	output logic off_event_o
);
	logic discharge_ff;
	logic fault1_ff;
	logic fault0_ff;
	logic saturated_ff;
	logic set_fault1;
	logic set_fault0;
	logic clr_history;

	// attempt while line low, or a shutdown caused by that line
	assign set_fault1 = (on_attempt_i & line1_low_i) | line1_shutdown_i;
	assign set_fault0 = (on_attempt_i & line0_low_i) | line0_shutdown_i;
	// history restarts on control toggle, on/off cycle or fault clearing
	assign clr_history = sticky_clear_i | history_clear_i;

	// discharge flag: set wins over clear so a coincident event is kept
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			discharge_ff <= 1'b0;
		end else if (discharge_fault_i) begin
			discharge_ff <= 1'b1;
		end else if (sticky_clear_i) begin
			discharge_ff <= 1'b0;
		end
	end

	// fault line 1 history flag
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fault1_ff <= 1'b0;
		end else if (set_fault1) begin
			fault1_ff <= 1'b1;
		end else if (clr_history) begin
			fault1_ff <= 1'b0;
		end
	end

	// fault line 0 history flag
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fault0_ff <= 1'b0;
		end else if (set_fault0) begin
			fault0_ff <= 1'b1;
		end else if (clr_history) begin
			fault0_ff <= 1'b0;
		end
	end

	// dac saturation latch, sticky but never alerting
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			saturated_ff <= 1'b0;
		end else if (servo_sat_i) begin
			saturated_ff <= 1'b1;
		end else if (sticky_clear_i) begin
			saturated_ff <= 1'b0;
		end
	end

	// paged byte; global bits 1 and 0 are filled in by the parent
	always_comb begin
		status_o = `RESET_STATUS;
		status_o[`BIT_DISCHARGE] = discharge_ff;
		status_o[`BIT_FAULT1] = fault1_ff;
		status_o[`BIT_FAULT0] = fault0_ff;
		status_o[`BIT_SERVO_REACHED] = servo_reached_i;
		status_o[`BIT_DAC_CONNECTED] = dac_connected_i;
		status_o[`BIT_DAC_SATURATED] = saturated_ff;
	end

	// only the three alerting bits; saturation is left out on purpose
	assign alerting_o = discharge_ff | fault1_ff | fault0_ff;
	// turn-off capable events only; live and saturation bits never stop a channel
	assign off_event_o = discharge_fault_i | set_fault1 | set_fault0;

endmodule : chan_status
`default_nettype wire

// ==== bench/mfr_readback_assertions.sv ====
// checker watching the top ports of the status and telemetry readback block
`timescale 1ns/1ps
`default_nettype none

module mfr_readback_chk (
	input wire logic mclk_i, rstn_i, cmd_valid_i, rd_valid_o, rd_two_bytes_o, rd_l11_o,
	input wire logic vinen_faulted_off_i, watchdog_fault_i, alert_out_n_o,
	input wire logic [7:0] cmd_code_i, servo_reached_i, adc_hires_cfg_i, adc_hires_sel_o,
	input wire logic [7:0] discharge_fault_i, on_attempt_i, line0_shutdown_i,
	input wire logic [7:0] line1_shutdown_i, off_event_o,
	input wire mfr_pkg::page_t page_i,
	input wire logic [15:0] rd_data_o
);
	import mfr_pkg::*;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	// answers to reads, one cycle after the taking edge
	AST_REV_FIXED: assert property (
		cmd_valid_i && cmd_code_i == 8'h98 |=> rd_data_o == 16'h0011 && !rd_two_bytes_o)
		else $error("revision answer wrong");
	AST_L11_WORD: assert property (
		cmd_valid_i && cmd_code_i inside {8'h88, 8'h8d} |=> rd_valid_o && rd_l11_o && rd_two_bytes_o)
		else $error("vin or temp answer not an l11 word");
	AST_LIVE_SERVO: assert property (
		cmd_valid_i && cmd_code_i == 8'h80 |=> rd_data_o[4] == $past(servo_reached_i[page_i]))
		else $error("servo bit not live for page");
	// vinen level is registered once, so the answer shows it two edges back
	AST_GLOBAL_VINEN: assert property (
		$past(rstn_i, 2) && cmd_valid_i && cmd_code_i == 8'h80
		|=> rd_data_o[1] == $past(vinen_faulted_off_i, 2))
		else $error("vinen bit wrong");
	AST_WD_ALERT: assert property (
		watchdog_fault_i |-> ##2 !alert_out_n_o)
		else $error("watchdog did not pull alert low");
	// off events: every discharge fault gives one, nothing without a cause gives one
	AST_DIS_OFF: assert property (
		discharge_fault_i != 8'h00
		|=> (off_event_o & $past(discharge_fault_i)) == $past(discharge_fault_i))
		else $error("discharge fault gave no off event");
	AST_OFF_CAUSE: assert property (
		off_event_o != 8'h00 |-> $past(discharge_fault_i | on_attempt_i | line0_shutdown_i
		| line1_shutdown_i) != 8'h00)
		else $error("off event without a capable cause");
	AST_HIRES_ODD: assert property (
		$past(rstn_i, 2) |-> adc_hires_sel_o == ($past(adc_hires_cfg_i) & 8'haa))
		else $error("hires select wrong");

	cover property (cmd_valid_i && cmd_code_i == 8'h80);
	cover property (!alert_out_n_o);
	cover property (rd_valid_o && rd_l11_o);
endmodule : mfr_readback_chk

`default_nettype wire

// ==== bench/host_model.sv ====
// host-side model issuing read commands on the block's command port
`timescale 1ns/1ps
`default_nettype none

module host_model (
	input wire logic mclk_i,
	output logic cmd_valid_o,
	output logic [7:0] cmd_code_o,
	output var mfr_pkg::page_t page_o,
	input wire logic rd_valid_i,
	input wire logic [15:0] rd_data_i
);
	import mfr_pkg::*;
	// idle bus at time zero
	initial begin
		cmd_valid_o = 1'b0;
		cmd_code_o = 8'h00;
		page_o = 3'h0;
	end
	// one read; the answer is taken at the rising edge where rd_valid is sampled high
	task automatic rd(input logic [7:0] code, input page_t pg, output logic [15:0] d);
		@(posedge mclk_i);
		cmd_valid_o <= 1'b1;
		cmd_code_o <= code;
		page_o <= pg;
		@(posedge mclk_i);
		cmd_valid_o <= 1'b0;
		// released bus carries inverted junk so stale values are never trusted
		cmd_code_o <= ~code;
		page_o <= ~pg;
		@(posedge mclk_i);
		d = (rd_valid_i === 1'b1) ? rd_data_i : 16'hxxxx;
	endtask : rd
endmodule : host_model

`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the status and telemetry readback block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import mfr_pkg::*;
	logic mclk_i, rstn_i, cmd_valid_i, rd_valid_o, rd_two_bytes_o, rd_l11_o, rd_unsupported_o;
	logic clear_faults_i, vinen_faulted_off_i, watchdog_fault_i, alert_out_n_o, adc_valid_i;
	logic shared_fault_line0_n_i, shared_fault_line1_n_i;
	logic [7:0] cmd_code_i, discharge_fault_i, on_attempt_i, line0_shutdown_i, line1_shutdown_i;
	logic [7:0] servo_reached_i, dac_connected_i, servo_sat_i, user_on_cmd_i, history_clear_i;
	logic [7:0] adc_hires_cfg_i, off_event_o, adc_hires_sel_o;
	page_t page_i, adc_chan_i;
	adc_src_t adc_src_i;
	word_t adc_word_i;
	logic [15:0] rd_data_o;
	int bad_count, tests_run;
	logic [7:0] off_seen;

	mfr_status_and_telemetry_readback uut (.*);
	host_model host (.mclk_i(mclk_i), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
		.page_o(page_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rq(input logic [7:0] code, input page_t pg, input logic [15:0] exp);
		logic [15:0] d;
		host.rd(code, pg, d);
		chk(d, exp);
	endtask : rq
	// answer qualifiers as {two_bytes, l11, unsupported}
	task automatic fl(input logic [2:0] exp);
		chk({13'h0000, rd_two_bytes_o, rd_l11_o, rd_unsupported_o}, {13'h0000, exp});
	endtask : fl
	// one-cycle event pulse, then two edges so flags and alert settle;
	// off_seen keeps the off-event pulse that the design shows one cycle after the cause
	task automatic ev(input int k, input logic [7:0] m);
		@(posedge mclk_i);
		case (k)
			0: discharge_fault_i <= m;
			1: on_attempt_i <= m;
			2: line1_shutdown_i <= m;
			3: servo_sat_i <= m;
			4: history_clear_i <= m;
			5: user_on_cmd_i <= m;
			6: watchdog_fault_i <= m[0];
			7: line0_shutdown_i <= m;
			default: clear_faults_i <= m[0];
		endcase
		@(posedge mclk_i);
		{discharge_fault_i, on_attempt_i, line1_shutdown_i, servo_sat_i, line0_shutdown_i} <= '0;
		{history_clear_i, user_on_cmd_i, watchdog_fault_i, clear_faults_i} <= '0;
		@(posedge mclk_i);
		off_seen = off_event_o;
		@(posedge mclk_i);
	endtask : ev
	task automatic adc(input adc_src_t s, input page_t c, input logic [15:0] w);
		@(posedge mclk_i);
		adc_valid_i <= 1'b1;
		adc_src_i <= s;
		adc_chan_i <= c;
		adc_word_i <= w;
		@(posedge mclk_i);
		adc_valid_i <= 1'b0;
		adc_word_i <= ~w;
	endtask : adc

	task automatic t_revision();
		rq(8'h98, 3'h0, 16'h0011);
		fl(3'b000);
		rq(8'h55, 3'h0, 16'h0000);
		fl(3'b001);
	endtask : t_revision
	task automatic t_adc();
		@(posedge mclk_i);
		adc_hires_cfg_i <= 8'h0c;
		@(posedge mclk_i);
		adc(ADC_SRC_VIN, 3'h0, 16'hd3a5);
		adc(ADC_SRC_TEMP, 3'h0, 16'he1c2);
		adc(ADC_SRC_VOUT, 3'h2, 16'h1234);
		adc(ADC_SRC_VOUT, 3'h3, 16'hb80f);
		adc(ADC_SRC_NONE, 3'h0, 16'h5a5a);
		chk({8'h00, adc_hires_sel_o}, 16'h0008);
		rq(8'h88, 3'h5, 16'hd3a5);
		fl(3'b110);
		rq(8'h8d, 3'h0, 16'he1c2);
		fl(3'b110);
		rq(8'h8b, 3'h2, 16'h1234);
		fl(3'b100);
		rq(8'h8b, 3'h3, 16'hb80f);
		fl(3'b110);
	endtask : t_adc
	task automatic t_live();
		@(posedge mclk_i);
		servo_reached_i <= 8'h02;
		dac_connected_i <= 8'h04;
		vinen_faulted_off_i <= 1'b1;
		rq(8'h80, 3'h1, 16'h0012);
		rq(8'h80, 3'h2, 16'h000a);
		@(posedge mclk_i);
		{servo_reached_i, dac_connected_i} <= '0;
		vinen_faulted_off_i <= 1'b0;
		rq(8'h80, 3'h2, 16'h0000);
	endtask : t_live
	task automatic t_sticky();
		ev(3, 8'h20);
		chk({15'h0000, alert_out_n_o}, 16'h0001);
		chk({8'h00, off_seen}, 16'h0000);
		ev(0, 8'h04);
		chk({8'h00, off_seen}, 16'h0004);
		ev(2, 8'h04);
		// both shared lines low, so one turn-on attempt sets both line flags
		@(posedge mclk_i);
		{shared_fault_line0_n_i, shared_fault_line1_n_i} <= 2'b00;
		repeat (3) @(posedge mclk_i);
		ev(1, 8'h20);
		chk({8'h00, off_seen}, 16'h0020);
		{shared_fault_line0_n_i, shared_fault_line1_n_i} <= 2'b11;
		repeat (3) @(posedge mclk_i);
		ev(1, 8'h10);
		chk({8'h00, off_seen}, 16'h0000);
		ev(7, 8'h40);
		ev(6, 8'h01);
		chk({8'h00, off_seen}, 16'h0000);
		chk({15'h0000, alert_out_n_o}, 16'h0000);
		rq(8'h80, 3'h2, 16'h00c1);
		rq(8'h80, 3'h5, 16'h0065);
		rq(8'h80, 3'h4, 16'h0001);
		rq(8'h80, 3'h6, 16'h0021);
		ev(4, 8'h04);
		rq(8'h80, 3'h2, 16'h0081);
		ev(5, 8'h04);
		rq(8'h80, 3'h2, 16'h0001);
		rq(8'h80, 3'h5, 16'h0065);
		ev(8, 8'h01);
		rq(8'h80, 3'h5, 16'h0000);
		chk({15'h0000, alert_out_n_o}, 16'h0001);
	endtask : t_sticky

	task automatic report_and_stop();
		if (bad_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop

	// 40 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	// run takes about 120 cycles; a hang is cut off well beyond that
	initial begin
		#(25 * 5000);
		bad_count++;
		report_and_stop();
	end
	// reset, then the scenarios in turn
	initial begin
		rstn_i = 1'b0;
		{discharge_fault_i, on_attempt_i, line0_shutdown_i, line1_shutdown_i} = '0;
		{servo_reached_i, dac_connected_i, servo_sat_i, user_on_cmd_i, history_clear_i} = '0;
		{clear_faults_i, vinen_faulted_off_i, watchdog_fault_i, adc_valid_i} = '0;
		{shared_fault_line0_n_i, shared_fault_line1_n_i} = 2'b11;
		adc_hires_cfg_i = 8'h00;
		adc_src_i = ADC_SRC_NONE;
		adc_chan_i = 3'h0;
		adc_word_i = 16'h0000;
		bad_count = 0;
		tests_run = 0;
		repeat (10) @(posedge mclk_i);
		rstn_i <= 1'b1;
		t_revision();
		t_adc();
		t_live();
		t_sticky();
		report_and_stop();
	end
endmodule : tb_top

bind mfr_status_and_telemetry_readback mfr_readback_chk chk (
	.mclk_i(mclk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i), .rd_valid_o(rd_valid_o),
	.rd_two_bytes_o(rd_two_bytes_o), .rd_l11_o(rd_l11_o),
	.vinen_faulted_off_i(vinen_faulted_off_i), .watchdog_fault_i(watchdog_fault_i),
	.alert_out_n_o(alert_out_n_o), .cmd_code_i(cmd_code_i), .servo_reached_i(servo_reached_i),
	.adc_hires_cfg_i(adc_hires_cfg_i), .adc_hires_sel_o(adc_hires_sel_o),
	.discharge_fault_i(discharge_fault_i), .on_attempt_i(on_attempt_i),
	.line0_shutdown_i(line0_shutdown_i), .line1_shutdown_i(line1_shutdown_i),
	.off_event_o(off_event_o), .page_i(page_i), .rd_data_o(rd_data_o)
);

`default_nettype wire
